// File: verilog/qspi_port_pkg.sv
// constants shared by the quad serial flash port and its shift engine
// assumes a single 125 MHz system clock; no software registers
package qspi_port_pkg;

  // ==========================================================
  // clock rates and serial clock divider
  localparam int SYS_CLK_MHZ  = 125;
  localparam int SCK_FAST_MHZ = 32;
  localparam int SCK_SLOW_MHZ = 16;
  // half periods round up so the serial clock never exceeds the limit
  localparam int HALF_FAST =
    (SYS_CLK_MHZ + 2 * SCK_FAST_MHZ - 1) / (2 * SCK_FAST_MHZ);
  localparam int HALF_SLOW =
    (SYS_CLK_MHZ + 2 * SCK_SLOW_MHZ - 1) / (2 * SCK_SLOW_MHZ);

  // ==========================================================
  // system address window
  localparam logic [11:0] WINDOW_TOP = 12'h100;
  localparam logic [20:0] CAP_128K   = 21'h020000;
  localparam logic [20:0] CAP_512K   = 21'h080000;
  localparam logic [20:0] CAP_1M     = 21'h100000;

  // ==========================================================
  // flash commands and phase lengths
  localparam logic [7:0] CMD_READ   = 8'h03;
  localparam logic [7:0] CMD_PROG   = 8'h02;
  localparam logic [7:0] CMD_QREAD  = 8'h6B;
  localparam logic [5:0] BITS_CMDAD = 6'h20;
  localparam logic [5:0] BITS_PROG  = 6'h28;
  localparam logic [5:0] BITS_BYTE  = 6'h08;
  localparam logic [3:0] QREAD_DUMMY = 4'h8;
  localparam logic [5:0] QREAD_BEATS = 6'h08;

  typedef enum logic [1:0] {
    CORE_SPI1,
    CORE_SWSHIFT,
    CORE_DIRECT,
    CORE_NONE
  } core_e;

endpackage : qspi_port_pkg

// File: verilog/flash_shifter.sv
// serial shift engine: command/address out, dummy, data in (1 or 4 bit)
// assumes halfTick is a one-cycle enable at twice the serial clock rate
`timescale 1ns/1ps
module flash_shifter (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        halfTick,
  input  wire logic        start,
  input  wire logic [39:0] txBits,
  input  wire logic [5:0]  txCount,
  input  wire logic [3:0]  dummyCount,
  input  wire logic [5:0]  rxCount,
  input  wire logic        rxQuad,
  input  wire logic        keepCs,
  input  wire logic [3:0]  ioSync,
  output logic             busy,
  output logic             done,
  output logic [31:0]      rxData,
  output logic             sck,
  output logic             csN,
  output logic [3:0]       ioOut,
  output logic [3:0]       ioOe
);

  typedef enum logic [2:0] {S_IDLE, S_TX, S_DUMMY, S_RX, S_FINISH} sh_e;

  typedef struct packed {
    sh_e         st;
    logic        sck;
    logic        csN;
    logic [3:0]  ioOut;
    logic [3:0]  ioOe;
    logic [39:0] sh;
    logic [5:0]  cnt;
    logic [3:0]  dum;
    logic [5:0]  rxn;
    logic        quad;
    logic [31:0] rx;
    logic        done;
  } shift_s;

  shift_s q, d;

  // ==========================================================
  // next state
  always_comb begin
    d      = q;
    d.done = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        d.csN  = ~keepCs;
        d.ioOe = 4'h0;
        if (start) begin
          d.csN  = 1'b0;
          d.sh   = txBits;
          d.dum  = dummyCount;
          d.rxn  = rxCount;
          d.quad = rxQuad;
          if (txCount != 6'h00) begin
            d.st    = S_TX;
            d.cnt   = txCount;
            d.ioOut = {3'h0, txBits[39]};
            d.ioOe  = 4'h1;
          end else begin
            d.st  = S_RX;
            d.cnt = rxCount;
          end
        end
      end
      S_FINISH: begin
        d.st   = S_IDLE;
        d.done = 1'b1;
        d.csN  = ~keepCs;
        d.ioOe = 4'h0;
      end
      default: begin
        if (halfTick && !q.sck) begin
          // rising edge
          d.sck = 1'b1;
        end else if (halfTick) begin
          // falling edge: advance to the next bit; the two-flop pin
          // delay leaves the bit launched at the last fall on ioSync now
          d.sck = 1'b0;
          d.cnt = q.cnt - 6'h01;
          if (q.st == S_RX) begin
            d.rx = q.quad ? {q.rx[27:0], ioSync} : {q.rx[30:0], ioSync[1]};
          end
          if (q.st == S_TX) begin
            d.sh    = {q.sh[38:0], 1'b0};
            d.ioOut = {3'h0, q.sh[38]};
          end
          if (q.cnt == 6'h01) begin
            d.ioOe = 4'h0;
            if (q.st == S_TX && q.dum != 4'h0) begin
              d.st  = S_DUMMY;
              d.cnt = {2'h0, q.dum};
            end else if (q.st != S_RX && q.rxn != 6'h00) begin
              d.st  = S_RX;
              d.cnt = q.rxn;
            end else begin
              d.st = S_FINISH;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q     <= '0;
      q.st  <= S_IDLE;
      q.csN <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign busy   = (q.st != S_IDLE);
  assign done   = q.done;
  assign rxData = q.rx;
  assign sck    = q.sck;
  assign csN    = q.csN;
  assign ioOut  = q.ioOut;
  assign ioOe   = q.ioOe;

endmodule : flash_shifter

// File: verilog/quad_spi_flash_port.sv
// quad serial flash port: three controller cores share one shift engine
// assumes requests come from logic on sys_clk; flash pins are asynchronous
//
// Operation
// R1 - serial clock never above 32 MHz
// R2 - three selectable cores master the interface
// R3 - single-bit core: indirect flash read and write
// R4 - software core only shifts bits
// R5 - direct core maps flash onto system addresses
// R6 - direct core generates command, address, data itself
// R7 - read cache serves repeated direct reads
// R8 - window 0x1000_0000 to 0x100F_FFFF decoded
// R9 - 128K, 512K, 1M capacities; window covers largest
// R10 - boost serial clock 32 MHz, else 16 MHz
// R11 - DMA granted before processor
// R12 - serial interface in its own rate domain
// R13 - only selected core drives the pins
// R14 - bus stalled until miss data arrives
`timescale 1ns/1ps
module quad_spi_flash_port #(
  parameter int CACHE_LINES = 16
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [1:0]  coreSel,
  input  wire logic        boost,
  input  wire logic [1:0]  flashSize,
  input  wire logic        cacheEnable,
  input  wire logic        cpuReq,
  input  wire logic [31:0] cpuAddr,
  input  wire logic        cpuWrite,
  input  wire logic        dmaReq,
  input  wire logic [31:0] dmaAddr,
  input  wire logic        dmaWrite,
  output logic             cpuAck,
  output logic             dmaAck,
  output logic             busErr,
  output logic [31:0]      busRdata,
  input  wire logic        indStart,
  input  wire logic        indWrite,
  input  wire logic [23:0] indAddr,
  input  wire logic [7:0]  indWdata,
  output logic [7:0]       indRdata,
  output logic             indDone,
  input  wire logic        swStart,
  input  wire logic        swOut,
  input  wire logic [7:0]  swByte,
  input  wire logic        swKeepCs,
  output logic [7:0]       swRdata,
  output logic             swDone,
  input  wire logic [3:0]  flashIoIn,
  output logic             flashSck,
  output logic             flashCsN,
  output logic [3:0]       flashIoOut,
  output logic [3:0]       flashIoOe
);

  localparam int IDX_W = $clog2(CACHE_LINES);
  localparam int TAG_W = 18 - IDX_W;

  if (CACHE_LINES < 2 || CACHE_LINES > 256 ||
      (CACHE_LINES & (CACHE_LINES - 1)) != 0) begin : g_bad_lines
    $error("CACHE_LINES must be a power of two from 2 to 256");
  end

  typedef enum logic [1:0] {T_IDLE, T_LOOKUP, T_FETCH, T_WAIT} top_e;

  typedef struct packed {
    top_e                                st;
    qspi_port_pkg::core_e                kind;
    logic                                owner;
    logic [2:0]                          div;
    logic                                tick;
    logic [3:0]                          ioS1;
    logic [3:0]                          ioS2;
    logic [23:0]                         opAddr;
    logic [7:0]                          opData;
    logic                                opWrite;
    logic                                engStart;
    logic [CACHE_LINES-1:0][31:0]        cData;
    logic [CACHE_LINES-1:0][TAG_W-1:0]   cTag;
    logic [CACHE_LINES-1:0]              cValid;
    logic                                cpuAck;
    logic                                dmaAck;
    logic                                err;
    logic [31:0]                         rdata;
    logic [7:0]                          indRdata;
    logic                                indDone;
    logic [7:0]                          swRdata;
    logic                                swDone;
  } port_s;

  port_s q, d;

  logic        engBusy;
  logic        engDone;
  logic [31:0] engRx;
  logic [39:0] engTx;
  logic [5:0]  engTxCnt;
  logic [3:0]  engDummy;
  logic [5:0]  engRxCnt;
  logic        engQuad;
  logic        engKeep;

  // ==========================================================
  // engine request multiplexer
  always_comb begin
    engTx    = '0;
    engTxCnt = '0;
    engDummy = '0;
    engRxCnt = '0;
    engQuad  = 1'b0;
    engKeep  = 1'b0;
    // R13 one core steers engine
    unique case (q.kind)
      // R3 single-bit indirect
      qspi_port_pkg::CORE_SPI1: begin
        engTx = {q.opWrite ? qspi_port_pkg::CMD_PROG : qspi_port_pkg::CMD_READ,
                 q.opAddr, q.opData};
        engTxCnt = q.opWrite ? qspi_port_pkg::BITS_PROG
                             : qspi_port_pkg::BITS_CMDAD;
        engRxCnt = q.opWrite ? 6'h00 : qspi_port_pkg::BITS_BYTE;
      end
      // R4 raw shift only
      qspi_port_pkg::CORE_SWSHIFT: begin
        engTx    = {q.opData, 32'h0000_0000};
        engTxCnt = q.opWrite ? qspi_port_pkg::BITS_BYTE : 6'h00;
        engRxCnt = q.opWrite ? 6'h00 : qspi_port_pkg::BITS_BYTE;
        engKeep  = swKeepCs;
      end
      // R6 hardware protocol
      qspi_port_pkg::CORE_DIRECT: begin
        engTx    = {qspi_port_pkg::CMD_QREAD, q.opAddr, 8'h00};
        engTxCnt = qspi_port_pkg::BITS_CMDAD;
        engDummy = qspi_port_pkg::QREAD_DUMMY;
        engRxCnt = qspi_port_pkg::QREAD_BEATS;
        engQuad  = 1'b1;
      end
      default: begin
        engTxCnt = '0;
      end
    endcase
  end

  // ==========================================================
  // request handling, arbitration and cache
  logic                 anyAck;
  logic                 pickDma;
  logic [31:0]          reqAddr;
  logic                 reqWrite;
  logic [20:0]          capacity;
  logic [IDX_W-1:0]     idx;
  logic                 hit;
  logic [2:0]           half;

  always_comb begin
    d          = q;
    d.cpuAck   = 1'b0;
    d.dmaAck   = 1'b0;
    d.indDone  = 1'b0;
    d.swDone   = 1'b0;
    d.engStart = 1'b0;
    d.ioS1     = flashIoIn;
    d.ioS2     = q.ioS1;
    // R1 R10 boost selects rate
    half = boost ? 3'(qspi_port_pkg::HALF_FAST)
                 : 3'(qspi_port_pkg::HALF_SLOW);
    // R12 serial rate enable
    d.tick = (q.div >= half - 3'h1);
    d.div  = d.tick ? 3'h0 : q.div + 3'h1;
    // R9 capacity select
    unique case (flashSize)
      2'h0:    capacity = qspi_port_pkg::CAP_128K;
      2'h1:    capacity = qspi_port_pkg::CAP_512K;
      default: capacity = qspi_port_pkg::CAP_1M;
    endcase
    anyAck   = q.cpuAck | q.dmaAck;
    // R11 DMA first
    pickDma  = dmaReq;
    reqAddr  = pickDma ? dmaAddr : cpuAddr;
    reqWrite = pickDma ? dmaWrite : cpuWrite;
    idx      = q.opAddr[IDX_W+1:2];
    hit      = q.cValid[idx] && q.cTag[idx] == q.opAddr[19:IDX_W+2];
    unique case (q.st)
      T_IDLE: begin
        // R2 core chosen by select
        if (coreSel == 2'(qspi_port_pkg::CORE_DIRECT) &&
            (dmaReq || cpuReq) && !anyAck) begin
          d.owner  = pickDma;
          d.kind   = qspi_port_pkg::CORE_DIRECT;
          d.opAddr = {4'h0, reqAddr[19:2], 2'h0};
          // R8 window decode
          if (reqAddr[31:20] != qspi_port_pkg::WINDOW_TOP || reqWrite ||
              {1'b0, reqAddr[19:0]} >= capacity) begin
            d.err    = 1'b1;
            d.dmaAck = pickDma;
            d.cpuAck = !pickDma;
          end else begin
            // R5 bus slave access
            d.st = T_LOOKUP;
          end
        end else if (coreSel == 2'(qspi_port_pkg::CORE_SPI1) && indStart) begin
          d.kind     = qspi_port_pkg::CORE_SPI1;
          d.opAddr   = indAddr;
          d.opData   = indWdata;
          d.opWrite  = indWrite;
          d.engStart = 1'b1;
          d.st       = T_WAIT;
        end else if (coreSel == 2'(qspi_port_pkg::CORE_SWSHIFT) &&
                     swStart) begin
          d.kind     = qspi_port_pkg::CORE_SWSHIFT;
          d.opData   = swByte;
          d.opWrite  = swOut;
          d.engStart = 1'b1;
          d.st       = T_WAIT;
        end
      end
      T_LOOKUP: begin
        // R7 cache hit answers at once
        if (cacheEnable && hit) begin
          d.err    = 1'b0;
          d.rdata  = q.cData[idx];
          d.dmaAck = q.owner;
          d.cpuAck = !q.owner;
          d.st     = T_IDLE;
        end else begin
          d.engStart = 1'b1;
          d.st       = T_FETCH;
        end
      end
      T_FETCH: begin
        // R14 hold bus until data shifted in
        if (engDone) begin
          d.err    = 1'b0;
          d.rdata  = {engRx[7:0], engRx[15:8], engRx[23:16], engRx[31:24]};
          d.dmaAck = q.owner;
          d.cpuAck = !q.owner;
          d.st     = T_IDLE;
          if (cacheEnable) begin
            d.cData[idx]  = d.rdata;
            d.cTag[idx]   = q.opAddr[19:IDX_W+2];
            d.cValid[idx] = 1'b1;
          end
        end
      end
      T_WAIT: begin
        if (engDone) begin
          d.st = T_IDLE;
          if (q.kind == qspi_port_pkg::CORE_SPI1) begin
            d.indRdata = engRx[7:0];
            d.indDone  = 1'b1;
            if (q.opWrite) begin
              d.cValid = '0;
            end
          end else begin
            d.swRdata = engRx[7:0];
            d.swDone  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q      <= '0;
      q.st   <= T_IDLE;
      q.kind <= qspi_port_pkg::CORE_NONE;
    end else begin
      q <= d;
    end
  end

  flash_shifter u_shift (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .halfTick   (q.tick),
    .start      (q.engStart),
    .txBits     (engTx),
    .txCount    (engTxCnt),
    .dummyCount (engDummy),
    .rxCount    (engRxCnt),
    .rxQuad     (engQuad),
    .keepCs     (engKeep),
    .ioSync     (q.ioS2),
    .busy       (engBusy),
    .done       (engDone),
    .rxData     (engRx),
    .sck        (flashSck),
    .csN        (flashCsN),
    .ioOut      (flashIoOut),
    .ioOe       (flashIoOe)
  );

  assign cpuAck   = q.cpuAck;
  assign dmaAck   = q.dmaAck;
  assign busErr   = q.err;
  assign busRdata = q.rdata;
  assign indRdata = q.indRdata;
  assign indDone  = q.indDone;
  assign swRdata  = q.swRdata;
  assign swDone   = q.swDone;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_dma_first: assert property ( // R11
    q.st == T_IDLE && coreSel == 2'(qspi_port_pkg::CORE_DIRECT) &&
    dmaReq && cpuReq && !anyAck |=> q.owner && !cpuAck)
    else $error("processor granted over DMA");

  chk_window_decode: assert property ( // R8
    q.st == T_IDLE && coreSel == 2'(qspi_port_pkg::CORE_DIRECT) &&
    dmaReq && !anyAck && dmaAddr[31:20] != 12'h100 |=> dmaAck && busErr)
    else $error("address outside window not refused");

  chk_capacity_limit: assert property ( // R9
    q.st == T_IDLE && coreSel == 2'(qspi_port_pkg::CORE_DIRECT) &&
    dmaReq && !anyAck && flashSize == 2'h0 &&
    dmaAddr[31:20] == 12'h100 && dmaAddr[19:17] != 3'h0 |=> busErr)
    else $error("access beyond capacity not refused");

  chk_cache_hit: assert property ( // R7
    q.st == T_LOOKUP && cacheEnable && hit |=>
    (cpuAck || dmaAck) && !engBusy)
    else $error("cache hit started a flash transfer");

  chk_miss_stall: assert property ( // R14
    q.st == T_LOOKUP && !(cacheEnable && hit) |=>
    (!cpuAck && !dmaAck) [*8])
    else $error("miss answered before flash data");

  chk_sck_fast: assert property ( // R1
    $changed(flashSck) |=> !$changed(flashSck))
    else $error("serial clock half period below two cycles");

  chk_sck_slow: assert property ( // R10
    !boost && $past(!boost) && $changed(flashSck) && !$past(boost, 2) |=>
    (!$changed(flashSck)) [*3])
    else $error("unboosted serial clock too fast");

  chk_core_isolate: assert property ( // R13
    !engBusy && $past(!engBusy) |->
    flashIoOe == 4'h0 && flashCsN == !$past(engKeep))
    else $error("pins driven with no transfer in flight");

endmodule : quad_spi_flash_port

// File: test/flash_model.sv
// behavioural serial flash answering read 03, program 02, quad read 6B
// assumes mode 0 and commands shifted in on io0, msb first
`timescale 1ns/1ps
module flash_model (
  input  wire logic       flashSck,
  input  wire logic       flashCsN,
  input  wire logic [3:0] flashIoOut,
  output logic      [3:0] flashIoIn
);
  // ==========================================================
  // storage and frame decode
  logic [7:0]  mem [int];
  logic [7:0]  cmd;
  logic [23:0] addr;
  logic [7:0]  wByte;
  logic [7:0]  rByte;
  logic [3:0]  drv = 4'h0;
  logic        drvOn = 1'h0;
  int          nRise = 0;
  int          k;

  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5A);
  endfunction : rd

  always @(negedge flashCsN) begin
    nRise = 0;
    cmd = 8'h00;
  end

  // released lines show the inverse of the last level
  always @(posedge flashCsN) begin
    drvOn = 1'h0;
    if (cmd == 8'h02 && nRise >= 40) mem[int'(addr)] = wByte;
  end

  always @(posedge flashSck) begin
    if (!flashCsN) begin
      if (nRise < 8) cmd = {cmd[6:0], flashIoOut[0]};
      else if (nRise < 32) addr = {addr[22:0], flashIoOut[0]};
      else wByte = {wByte[6:0], flashIoOut[0]};
      nRise++;
    end
  end

  // data launched on the falling edge, sampled by the port at the next fall
  always @(negedge flashSck) begin
    if (!flashCsN && cmd == 8'h03 && nRise >= 32) begin
      k = nRise - 32;
      rByte = rd(int'(addr) + k / 8);
      drv[1] = rByte[7 - k % 8];
      drvOn = 1'h1;
    end
    if (!flashCsN && cmd == 8'h6B && nRise >= 40) begin
      k = nRise - 40;
      rByte = rd(int'(addr) + k / 2);
      drv = k[0] ? rByte[3:0] : rByte[7:4];
      drvOn = 1'h1;
    end
  end

  assign flashIoIn = drvOn ? drv : ~drv;
endmodule : flash_model

// File: test/tb_top.sv
// self-checking bench for the quad serial flash port
// assumes flash_model on the pins; inputs change 1 ns after sys_clk rise
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // stimulus, design and flash
  logic sys_clk = 1'h0, reset = 1'h1, boost = 1'h1, cacheEnable = 1'h1;
  logic [1:0] coreSel = 2'h3, flashSize = 2'h2;
  logic cpuReq = 1'h0, cpuWrite = 1'h0, dmaReq = 1'h0, dmaWrite = 1'h0;
  logic [31:0] cpuAddr = 32'h0, dmaAddr = 32'h0, busRdata;
  logic cpuAck, dmaAck, busErr, indDone, swDone, flashSck, flashCsN;
  logic indStart = 1'h0, indWrite = 1'h0, swStart = 1'h0, swOut = 1'h0;
  logic swKeepCs = 1'h0;
  logic [23:0] indAddr = 24'h0, progA = 24'h0;
  logic [7:0] indWdata = 8'h0, swByte = 8'h0, indRdata, swRdata;
  logic [7:0] progV = 8'h0;
  logic progOn = 1'h0;
  logic [3:0] flashIoIn, flashIoOut, flashIoOe;
  int miscompares = 0, nCompared = 0, csFalls = 0;
  realtime lastRise = 0, minPer = 1.0e9;

  always #4 sys_clk = ~sys_clk;

  quad_spi_flash_port #(.CACHE_LINES(16)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .coreSel(coreSel), .boost(boost),
    .flashSize(flashSize), .cacheEnable(cacheEnable), .cpuReq(cpuReq),
    .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .dmaReq(dmaReq),
    .dmaAddr(dmaAddr), .dmaWrite(dmaWrite), .cpuAck(cpuAck),
    .dmaAck(dmaAck), .busErr(busErr), .busRdata(busRdata),
    .indStart(indStart), .indWrite(indWrite), .indAddr(indAddr),
    .indWdata(indWdata), .indRdata(indRdata), .indDone(indDone),
    .swStart(swStart), .swOut(swOut), .swByte(swByte),
    .swKeepCs(swKeepCs), .swRdata(swRdata), .swDone(swDone),
    .flashIoIn(flashIoIn), .flashSck(flashSck), .flashCsN(flashCsN),
    .flashIoOut(flashIoOut), .flashIoOe(flashIoOe));

  flash_model i_flash (.flashSck(flashSck), .flashCsN(flashCsN),
    .flashIoOut(flashIoOut), .flashIoIn(flashIoIn));

  always @(negedge flashCsN) csFalls++;
  always @(posedge flashSck) begin
    if ($realtime - lastRise < minPer) minPer = $realtime - lastRise;
    lastRise = $realtime;
  end

  // ==========================================================
  // helpers
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic cmp_word(input logic [31:0] g, e, input string w);
    nCompared++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: %s got %h want %h", $time, w, g, e);
    end
  endtask : cmp_word

  task automatic cmp_true(input bit ok, input string w);
    nCompared++;
    if (!ok) begin
      miscompares++;
      $display("Error at %0t: %s", $time, w);
    end
  endtask : cmp_true

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    do begin
      tick();
      n++;
    end while (s !== 1'h1 && n < 4000);
    if (s !== 1'h1) begin
      miscompares++;
      $display("Error at %0t: wait timed out", $time);
      finish_test();
    end
  endtask : wait_hi

  function automatic logic [7:0] eb(input logic [23:0] a);
    return (progOn && a == progA) ? progV : (a[7:0] ^ 8'h5A);
  endfunction : eb

  function automatic logic [31:0] ew(input logic [23:0] a);
    return {eb(a + 24'h3), eb(a + 24'h2), eb(a + 24'h1), eb(a)};
  endfunction : ew

  task automatic bus(input bit dma, input logic [31:0] a, input logic w,
                     output logic [31:0] d, output logic e, output int n);
    tick();
    cpuAddr = a;
    dmaAddr = a;
    cpuWrite = w;
    dmaWrite = w;
    cpuReq = !dma;
    dmaReq = dma;
    if (dma) wait_hi(dmaAck, n);
    else wait_hi(cpuAck, n);
    d = busRdata;
    e = busErr;
    tick();
    cpuReq = 1'h0;
    dmaReq = 1'h0;
  endtask : bus

  task automatic ind(input logic w, input logic [23:0] a,
                     input logic [7:0] v, output logic [7:0] r);
    int n;
    indWrite = w;
    indAddr = a;
    indWdata = v;
    indStart = 1'h1;
    tick();
    indStart = 1'h0;
    wait_hi(indDone, n);
    r = indRdata;
    tick();
  endtask : ind

  task automatic sw(input logic o, input logic [7:0] v, input logic keep,
                    output logic [7:0] r);
    int n;
    swOut = o;
    swByte = v;
    swStart = 1'h1;
    tick();
    swStart = 1'h0;
    swKeepCs = keep;
    wait_hi(swDone, n);
    r = swRdata;
    tick();
  endtask : sw

  // ==========================================================
  // scenarios
  task automatic t_direct();
    logic [31:0] d;
    logic e;
    int n, f;
    coreSel = 2'h2;
    minPer = 1.0e9;
    bus(1'h0, 32'h1000_0040, 1'h0, d, e, n);
    cmp_word(d, ew(24'h40), "miss data");
    cmp_word({24'h0, i_flash.cmd}, 32'h6B, "fetch command");
    cmp_true(e === 1'h0 && n > 40, "miss stall");
    f = csFalls;
    bus(1'h0, 32'h1000_0040, 1'h0, d, e, n);
    cmp_word(d, ew(24'h40), "hit data");
    cmp_true(n <= 3 && csFalls == f, "hit without flash");
    cmp_true(minPer >= 31.25, "fast sck period");
  endtask : t_direct

  task automatic t_priority();
    int n;
    tick();
    cpuAddr = 32'h1000_0040;
    dmaAddr = 32'h1000_0040;
    cpuReq = 1'h1;
    dmaReq = 1'h1;
    wait_hi(dmaAck, n);
    cmp_word({30'h0, dmaAck, cpuAck}, 32'h2, "dma first");
    tick();
    dmaReq = 1'h0;
    wait_hi(cpuAck, n);
    tick();
    cpuReq = 1'h0;
  endtask : t_priority

  task automatic t_window();
    logic [31:0] ad [6] = '{32'h0FFF_FFFC, 32'h1010_0000, 32'h1002_0000,
                            32'h1001_FFFC, 32'h1008_0000, 32'h100F_FFFC};
    logic [1:0] sz [6] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h3};
    logic er [6] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
    logic [31:0] d;
    logic e;
    int n, f;
    for (int i = 0; i < 6; i++) begin
      flashSize = sz[i];
      f = csFalls;
      bus(i % 3 != 0, ad[i], 1'h0, d, e, n);
      cmp_word({31'h0, e}, {31'h0, er[i]}, "window decode");
      if (er[i]) cmp_true(csFalls == f, "refused no flash");
      else cmp_word(d, ew(ad[i][23:0]), "window data");
    end
    bus(1'h1, 32'h1000_0040, 1'h1, d, e, n);
    cmp_word({31'h0, e}, 32'h1, "write refused");
    flashSize = 2'h2;
  endtask : t_window

  task automatic t_single();
    logic [31:0] d;
    logic [7:0] r;
    logic e;
    int n;
    bus(1'h0, 32'h1000_0100, 1'h0, d, e, n);
    coreSel = 2'h0;
    ind(1'h1, 24'h000100, 8'hC3, r);
    progA = 24'h100;
    progV = 8'hC3;
    progOn = 1'h1;
    ind(1'h0, 24'h000100, 8'h00, r);
    cmp_word({24'h0, r}, {24'h0, eb(24'h100)}, "indirect rd");
    ind(1'h0, 24'h000105, 8'h00, r);
    cmp_word({24'h0, r}, {24'h0, eb(24'h105)}, "indirect rd2");
    coreSel = 2'h2;
    bus(1'h0, 32'h1000_0100, 1'h0, d, e, n);
    cmp_word(d, ew(24'h100), "refetch after program");
  endtask : t_single

  task automatic t_soft();
    logic [7:0] hdr [4] = '{8'h03, 8'h00, 8'h02, 8'h07};
    logic [7:0] r;
    coreSel = 2'h1;
    foreach (hdr[i]) sw(1'h1, hdr[i], 1'h1, r);
    cmp_true(flashCsN === 1'h0, "select held");
    sw(1'h0, 8'h00, 1'h0, r);
    cmp_word({24'h0, r}, {24'h0, eb(24'h207)}, "shift in");
    repeat (2) tick();
    cmp_true(flashCsN === 1'h1, "select released");
  endtask : t_soft

  task automatic t_isolate();
    logic seen;
    int f;
    seen = 1'h0;
    f = csFalls;
    coreSel = 2'h2;
    indStart = 1'h1;
    swStart = 1'h1;
    tick();
    indStart = 1'h0;
    swStart = 1'h0;
    repeat (200) begin
      tick();
      seen = seen | indDone | swDone | (flashIoOe !== 4'h0);
    end
    cmp_true(seen === 1'h0 && csFalls == f, "other cores idle");
  endtask : t_isolate

  task automatic t_slow();
    logic [31:0] d;
    logic e;
    int n, f;
    boost = 1'h0;
    cacheEnable = 1'h0;
    minPer = 1.0e9;
    bus(1'h0, 32'h1000_0080, 1'h0, d, e, n);
    f = csFalls;
    bus(1'h1, 32'h1000_0080, 1'h0, d, e, n);
    cmp_word(d, ew(24'h80), "uncached data");
    cmp_true(csFalls == f + 1, "no cache when off");
    cmp_true(minPer >= 62.5, "slow sck period");
  endtask : t_slow

  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    cmp_word({29'h0, flashCsN, flashSck, cpuAck}, 32'h4, "reset pins");
    reset = 1'h0;
    t_direct();
    t_priority();
    t_window();
    t_single();
    t_soft();
    t_isolate();
    t_slow();
    finish_test();
  end
endmodule : tb_top
